// ===== verilog/uara_pkg.sv
// Constants, register map and clock-source table of the async serial channel.
// Assumes a 32-bit AXI4-Lite bus; printed offsets are word indices.
package uara_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register word indices; byte address is four times the index
   localparam logic [23:0] IDX_HALT = 24'h0FFDCC;
   localparam logic [23:0] IDX_FRAME = 24'hFFF600;
   localparam logic [23:0] IDX_CTRL = 24'hFFF602;
   localparam logic [23:0] IDX_TXHOLD = 24'hFFF603;
   localparam logic [23:0] IDX_FLAG = 24'hFFF604;
   localparam logic [23:0] IDX_RXHOLD = 24'hFFF605;
   localparam logic [23:0] IDX_CARD = 24'hFFF606;
   localparam logic [23:0] IDX_EXTCLK = 24'hFFF608;
   localparam logic [23:0] IDX_BAUDDIV = 24'hFFF60A;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int HALT_BIT = 15;
   localparam int MODE_SYNC_BIT = 7;
   localparam int CHAR_LEN_BIT = 6;
   localparam int PARITY_ON_BIT = 5;
   localparam int STOP_LEN_BIT = 3;
   localparam int TX_EN_BIT = 5;
   localparam int RX_ON_BIT = 4;
   localparam int CLK_SRC_HI_BIT = 1;
   localparam int TX_HOLDING_EMPTY_BIT = 7;
   localparam int RX_HOLDING_FULL_BIT = 6;
   localparam int OVERRUN_FLAG_BIT = 5;
   localparam int FER_BIT = 4;
   localparam int PER_BIT = 3;
   localparam int TX_DONE_FLAG_BIT = 2;
   localparam int SMARTCARD_BIT = 0;
   localparam int BASE_DIV_BIT = 4;
   localparam int ACS_MSB = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] HALT_RST = 16'h8000;
   localparam logic [7:0] REG8_RST = 8'h00;
   localparam logic [7:0] BAUDDIV_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Bus answers, oversampling and clock-source codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [4:0] OVS16 = 5'h10;
   localparam logic [4:0] OVS8 = 5'h08;
   localparam logic [3:0] BITS8 = 4'h8;
   localparam logic [3:0] BITS7 = 4'h7;
   localparam logic [3:0] ACS_NONE = 4'h0;
   localparam logic [3:0] ACS_TMR = 4'h4;
   localparam logic [3:0] ACS_921K = 4'h3;
   localparam logic [6:0] KEEP_921K = 7'h2F;
   localparam logic [6:0] PERIOD_921K = 7'h33;
   localparam logic [6:0] KEEP_ALL = 7'h01;

   function automatic logic [31:0] regAddr(input logic [23:0] idx);
      regAddr = {6'h00, idx, 2'h0};
   endfunction : regAddr

   // Average-rate code in use
   function automatic logic avgUsed(input logic [3:0] code);
      avgUsed = (code != ACS_NONE) && (code != ACS_TMR) && (code <= 4'hC);
   endfunction : avgUsed

   // Codes that give one bit per 8 base periods
   function automatic logic avgEighth(input logic [3:0] code);
      avgEighth = (code == 4'h2) || (code == 4'h3) || (code == 4'h7) ||
                  (code == 4'hA) || (code == 4'hB);
   endfunction : avgEighth

   // Kept halved-clock cycles and window per code
   function automatic logic [6:0] avgKeep(input logic [3:0] code);
      avgKeep = (code == ACS_921K) ? KEEP_921K : KEEP_ALL;
   endfunction : avgKeep

   function automatic logic [6:0] avgPeriod(input logic [3:0] code);
      avgPeriod = (code == ACS_921K) ? PERIOD_921K : KEEP_ALL;
   endfunction : avgPeriod

endpackage : uara_pkg

// ===== verilog/uara_uart_avg_rate_async.sv
// Async serial channel with average-rate clock source and AXI4-Lite registers.
// Assumes one clock; rxd, tmrBaseTick and DMA strobes are synchronous to it.
`timescale 1ns/100ps

// Contract
// [R1] Halt bit 15 set stops the serial unit; cleared lets it run.
// [R2] Frame bit 7 selects asynchronous (0) or clock-synchronous (1) operation; at 1 the unit stops instead.
// [R3] Frame bit 6 gives 8 data bits at 0, 7 data bits at 1.
// [R4] Frame bit 5 adds a parity bit when 1, omits it when 0.
// [R5] Frame bit 3 gives one or two stop bits; receiver checks only the first.
// [R6] Control bits 5 and 4 switch transmit and receive on or off.
// [R7] Clock source 00 uses internal generator; upper bit 1 uses timer or average generator.
// [R8] Holding-empty flag sets when transmit disabled or byte moves to shifter.
// [R9] Holding-empty clears by 0 write after reading 1, or DMA write.
// [R10] Holding-full flag sets on good reception; clears by 0 write or DMA read.
// [R11] Clearing receive enable leaves holding-full flag unchanged.
// [R12] Reception while holding-full is 1 sets overrun and drops the character.
// [R13] Framing and parity flags set on error; clear by 0 write after reading 1.
// [R14] Status flags accept only 0 writes; writing 1 never sets them.
// [R15] Transmit-end is 1 when transmit off, or last bit sent with holding empty.
// [R16] Transmit holding register is read-write; receive holding register read-only.
// [R17] Card-mode bit 0 selects normal operation at 0, smart-card at 1; at 1 the unit stops instead.
// [R18] Base-clock select bit 4 gives 16 base periods per bit at 0, 8 at 1.
// [R19] Source code 0000 leaves average generator unused; 0100 takes timer compare ticks.
// [R20] Listed codes give 16 or 8 average-rate base periods per bit.
// [R21] Code 0011 at 16 MHz yields 921.569 kbps average rate.
// [R22] With an average-rate code, base-clock select bit is ignored.
// [R23] Source code acts only in async mode with upper clock source bit 1.
// [R24] Code 0011 halves the clock and keeps 47 of every 51 cycles.
// [R25] A bit spans eight base-clock cycles, 8 or 9 halved cycles.
// [R26] Frames: low start, data LSB first, high stop bits, line idles high.
module uara_uart_avg_rate_async (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rxd,
   output logic txd,
   input wire logic tmrBaseTick,
   output logic txEmptyIrq,
   output logic rxFullIrq,
   input wire logic dmaTxWrite,
   input wire logic [7:0] dmaTxData,
   input wire logic dmaRxRead,
   output logic [7:0] rxData
);
   import uara_pkg::*;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uara_tx_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uara_rx_e;

   logic [1:0] rstSync;
   logic rstN;
   logic awHeld, wHeld, arHeld, next_awHeld, next_wHeld, next_arHeld;
   logic [31:0] awAddrQ, wDataQ, arAddrQ, readWord;
   logic [3:0] wStrbQ;
   logic doWrite, doRead, readHit;
   logic [15:0] haltReg;
   logic [7:0] frameReg, ctrlReg, txHold, rxHold, cardReg, extClkReg, baudDiv;
   logic [7:0] flagSeen, flagWr, flagRead;
   logic tx_holding_empty, rx_holding_full, overrun_flag, framing_flag, parity_fault_flag, tx_done_flag, flagClrTx;
   logic run, te, re, useAvg, baseTick, divTick, avgTick, halfPhase;
   logic [7:0] divCnt;
   logic [6:0] avgAcc, avgSum;
   logic [4:0] tpb;
   logic [3:0] dataBits;
   uara_tx_e txState;
   uara_rx_e rxState;
   logic [4:0] txTicks, rxTicks;
   logic [3:0] txIdx, rxIdx;
   logic [7:0] txShift, rxShift;
   logic txPar, txStop2nd, txLoad, txBitEnd, txLastBit;
   logic rxPar, rxBitEnd, rxDone, rxStopBad, rxParBad;
   logic [7:0] rxWord;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshakes
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign doRead = arHeld && !s_axi_rvalid;
   assign next_awHeld = doWrite ? 1'b0 : (awHeld || (s_axi_awvalid && s_axi_awready));
   assign next_wHeld = doWrite ? 1'b0 : (wHeld || (s_axi_wvalid && s_axi_wready));
   assign next_arHeld = doRead ? 1'b0 : (arHeld || (s_axi_arvalid && s_axi_arready));

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         {awHeld, wHeld, arHeld} <= 3'h0;
         {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h0;
         {s_axi_bvalid, s_axi_rvalid} <= 2'h0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         awAddrQ <= 32'h00000000;
         wDataQ <= 32'h00000000;
         arAddrQ <= 32'h00000000;
         wStrbQ <= 4'h0;
      end else if (clkEn) begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         arHeld <= next_arHeld;
         s_axi_awready <= !next_awHeld;
         s_axi_wready <= !next_wHeld;
         s_axi_arready <= !next_arHeld;
         if (s_axi_awvalid && s_axi_awready) begin
            awAddrQ <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            arAddrQ <= s_axi_araddr;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddrQ == regAddr(IDX_HALT) || awAddrQ == regAddr(IDX_FRAME) ||
               awAddrQ == regAddr(IDX_CTRL) || awAddrQ == regAddr(IDX_TXHOLD) ||
               awAddrQ == regAddr(IDX_FLAG) || awAddrQ == regAddr(IDX_RXHOLD) ||
               awAddrQ == regAddr(IDX_CARD) || awAddrQ == regAddr(IDX_EXTCLK) ||
               awAddrQ == regAddr(IDX_BAUDDIV)) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readWord;
            s_axi_rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read decode
   assign flagRead = {tx_holding_empty, rx_holding_full, overrun_flag, framing_flag, parity_fault_flag, tx_done_flag, 2'h0};

   always_comb begin
      readHit = 1'b1;
      readWord = 32'h00000000;
      if (arAddrQ == regAddr(IDX_HALT)) begin
         readWord = {16'h0000, haltReg};
      end else if (arAddrQ == regAddr(IDX_FRAME)) begin
         readWord = {24'h000000, frameReg};
      end else if (arAddrQ == regAddr(IDX_CTRL)) begin
         readWord = {24'h000000, ctrlReg};
      end else if (arAddrQ == regAddr(IDX_TXHOLD)) begin
         readWord = {24'h000000, txHold}; // R16
      end else if (arAddrQ == regAddr(IDX_FLAG)) begin
         readWord = {24'h000000, flagRead};
      end else if (arAddrQ == regAddr(IDX_RXHOLD)) begin
         readWord = {24'h000000, rxHold};
      end else if (arAddrQ == regAddr(IDX_CARD)) begin
         readWord = {24'h000000, cardReg};
      end else if (arAddrQ == regAddr(IDX_EXTCLK)) begin
         readWord = {24'h000000, extClkReg};
      end else if (arAddrQ == regAddr(IDX_BAUDDIV)) begin
         readWord = {24'h000000, baudDiv};
      end else begin
         readHit = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         haltReg <= HALT_RST;
         {frameReg, ctrlReg, cardReg, extClkReg, txHold} <= {5{REG8_RST}};
         baudDiv <= BAUDDIV_RST;
      end else if (clkEn) begin
         if (doWrite && wStrbQ[0]) begin
            if (awAddrQ == regAddr(IDX_HALT)) haltReg[7:0] <= wDataQ[7:0];
            if (awAddrQ == regAddr(IDX_FRAME)) frameReg <= wDataQ[7:0];
            if (awAddrQ == regAddr(IDX_CTRL)) ctrlReg <= wDataQ[7:0];
            if (awAddrQ == regAddr(IDX_CARD)) cardReg <= wDataQ[7:0];
            if (awAddrQ == regAddr(IDX_EXTCLK)) extClkReg <= wDataQ[7:0];
            if (awAddrQ == regAddr(IDX_BAUDDIV)) baudDiv <= wDataQ[7:0];
         end
         if (doWrite && wStrbQ[1] && awAddrQ == regAddr(IDX_HALT)) begin
            haltReg[15:8] <= wDataQ[15:8];
         end
         if (dmaTxWrite) begin
            txHold <= dmaTxData;
         end else if (doWrite && wStrbQ[0] && awAddrQ == regAddr(IDX_TXHOLD)) begin
            txHold <= wDataQ[7:0]; // R16
         end
      end
   end

   assign run = !haltReg[HALT_BIT] && !frameReg[MODE_SYNC_BIT] && !cardReg[SMARTCARD_BIT]; // R1 R2 R17
   assign te = ctrlReg[TX_EN_BIT]; // R6
   assign re = ctrlReg[RX_ON_BIT]; // R6
   assign dataBits = frameReg[CHAR_LEN_BIT] ? BITS7 : BITS8; // R3

   ////////////////////////////////////////////////////////////////////////////
   // Status flags
   assign flagWr = (doWrite && wStrbQ[0] && awAddrQ == regAddr(IDX_FLAG)) ?
                   (~wDataQ[7:0] & flagSeen) : 8'h00; // R14
   assign flagClrTx = flagWr[TX_HOLDING_EMPTY_BIT] || dmaTxWrite; // R9

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         flagSeen <= 8'h00;
      end else if (clkEn) begin
         if (doRead && arAddrQ == regAddr(IDX_FLAG)) begin
            flagSeen <= flagRead;
         end else if (doWrite && awAddrQ == regAddr(IDX_FLAG)) begin
            flagSeen <= 8'h00;
         end
      end
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         {tx_holding_empty, tx_done_flag} <= 2'h3;
         {rx_holding_full, overrun_flag, framing_flag, parity_fault_flag} <= 4'h0;
         rxHold <= REG8_RST;
      end else if (clkEn) begin
         if (!te || txLoad) tx_holding_empty <= 1'b1; // R8
         else if (flagClrTx) tx_holding_empty <= 1'b0; // R9
         if (!te || (txLastBit && tx_holding_empty)) tx_done_flag <= 1'b1; // R15
         else if (flagClrTx) tx_done_flag <= 1'b0; // R15
         if (rxDone && !rx_holding_full && !rxStopBad && !rxParBad) begin
            rx_holding_full <= 1'b1; // R10 R11
            rxHold <= rxWord;
         end else if (flagWr[RX_HOLDING_FULL_BIT] || dmaRxRead) begin
            rx_holding_full <= 1'b0; // R10
         end
         if (rxDone && rx_holding_full) overrun_flag <= 1'b1; // R12
         else if (flagWr[OVERRUN_FLAG_BIT]) overrun_flag <= 1'b0; // R14
         if (rxDone && rxStopBad) framing_flag <= 1'b1; // R13
         else if (flagWr[FER_BIT]) framing_flag <= 1'b0; // R13
         if (rxDone && rxParBad) parity_fault_flag <= 1'b1; // R13
         else if (flagWr[PER_BIT]) parity_fault_flag <= 1'b0; // R13
      end
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         {txEmptyIrq, rxFullIrq} <= 2'h0;
         rxData <= REG8_RST;
      end else if (clkEn) begin
         txEmptyIrq <= te && tx_holding_empty;
         rxFullIrq <= re && rx_holding_full;
         rxData <= rxHold;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Base clock sources
   assign useAvg = !frameReg[MODE_SYNC_BIT] && ctrlReg[CLK_SRC_HI_BIT] &&
                   avgUsed(extClkReg[ACS_MSB:0]); // R23
   assign avgSum = avgAcc + avgKeep(extClkReg[ACS_MSB:0]);
   assign avgTick = halfPhase && (avgSum >= avgPeriod(extClkReg[ACS_MSB:0])); // R24
   assign baseTick = useAvg ? avgTick :
                     ctrlReg[CLK_SRC_HI_BIT] ? tmrBaseTick : divTick; // R7 R19
   assign tpb = useAvg ? (avgEighth(extClkReg[ACS_MSB:0]) ? OVS8 : OVS16) :
                (extClkReg[BASE_DIV_BIT] ? OVS8 : OVS16); // R18 R20 R22 R25
   assign divTick = (divCnt == 8'h00);

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         divCnt <= BAUDDIV_RST;
         halfPhase <= 1'b0;
         avgAcc <= 7'h00;
      end else if (clkEn && run) begin
         divCnt <= divTick ? baudDiv : divCnt - 8'h01;
         halfPhase <= !halfPhase; // R24
         if (halfPhase) begin
            avgAcc <= avgTick ? 7'(avgSum - avgPeriod(extClkReg[ACS_MSB:0])) : avgSum; // R21
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter
   assign txLoad = run && te && !tx_holding_empty && txState == TX_IDLE; // R8
   assign txBitEnd = baseTick && txTicks == tpb - 5'h01;

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         txState <= TX_IDLE;
         txd <= 1'b1;
         {txTicks, txIdx, txShift} <= 17'h00000;
         {txPar, txStop2nd, txLastBit} <= 3'h0;
      end else if (clkEn) begin
         txLastBit <= 1'b0;
         if (!te) begin
            txState <= TX_IDLE; // R6
            txd <= 1'b1;
         end else if (run) begin
            if (baseTick) txTicks <= txBitEnd ? 5'h00 : txTicks + 5'h01;
            unique case (txState)
               TX_IDLE: if (txLoad) begin
                  txShift <= txHold;
                  txPar <= ^(frameReg[CHAR_LEN_BIT] ? {1'b0, txHold[6:0]} : txHold);
                  txd <= 1'b0; // R26
                  txTicks <= 5'h00;
                  txState <= TX_START;
               end
               TX_START: if (txBitEnd) begin
                  txd <= txShift[0]; // R26
                  txShift <= {1'b0, txShift[7:1]};
                  txIdx <= 4'h1;
                  txState <= TX_DATA;
               end
               TX_DATA: if (txBitEnd) begin
                  if (txIdx == dataBits) begin
                     txd <= frameReg[PARITY_ON_BIT] ? txPar : 1'b1; // R4
                     txStop2nd <= 1'b0;
                     txState <= frameReg[PARITY_ON_BIT] ? TX_PAR : TX_STOP;
                  end else begin
                     txd <= txShift[0]; // R3
                     txShift <= {1'b0, txShift[7:1]};
                     txIdx <= txIdx + 4'h1;
                  end
               end
               TX_PAR: if (txBitEnd) begin
                  txd <= 1'b1;
                  txStop2nd <= 1'b0;
                  txState <= TX_STOP;
               end
               TX_STOP: if (txBitEnd) begin
                  if (frameReg[STOP_LEN_BIT] && !txStop2nd) begin
                     txStop2nd <= 1'b1; // R5
                  end else begin
                     txLastBit <= 1'b1; // R15
                     txState <= TX_IDLE;
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver
   assign rxBitEnd = baseTick && rxTicks == tpb - 5'h01;

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         rxState <= RX_IDLE;
         {rxTicks, rxIdx, rxShift, rxWord} <= 25'h0000000;
         {rxPar, rxDone, rxStopBad, rxParBad} <= 4'h0;
      end else if (clkEn) begin
         rxDone <= 1'b0;
         if (!re) begin
            rxState <= RX_IDLE; // R6 R11
         end else if (run) begin
            if (baseTick) rxTicks <= rxBitEnd ? 5'h00 : rxTicks + 5'h01;
            unique case (rxState)
               RX_IDLE: if (baseTick && !rxd) begin
                  rxTicks <= 5'h00; // R26
                  rxState <= RX_START;
               end
               RX_START: if (baseTick && rxTicks == (tpb >> 1) - 5'h01) begin
                  rxTicks <= 5'h00;
                  rxIdx <= 4'h0;
                  rxPar <= 1'b0;
                  rxState <= rxd ? RX_IDLE : RX_DATA;
               end
               RX_DATA: if (rxBitEnd) begin
                  rxShift <= {rxd, rxShift[7:1]}; // R26
                  rxPar <= rxPar ^ rxd;
                  rxIdx <= rxIdx + 4'h1;
                  if (rxIdx == dataBits - 4'h1) begin
                     rxState <= frameReg[PARITY_ON_BIT] ? RX_PAR : RX_STOP; // R4
                  end
               end
               RX_PAR: if (rxBitEnd) begin
                  rxParBad <= rxPar ^ rxd;
                  rxState <= RX_STOP;
               end
               RX_STOP: if (rxBitEnd) begin
                  rxStopBad <= !rxd; // R5
                  rxWord <= frameReg[CHAR_LEN_BIT] ? {1'b0, rxShift[7:1]} : rxShift; // R3
                  rxDone <= 1'b1; // R10 R12
                  rxState <= RX_IDLE;
               end
            endcase
            if (rxState == RX_START) rxParBad <= 1'b0;
         end
      end
   end

endmodule : uara_uart_avg_rate_async

// ===== verif/uara_uart_monitor.sv
// Bus handshake and serial line checker for the async channel.
// Assumes binding to the top module with clkEn held high.
`timescale 1ns/100ps
module uara_uart_monitor
   import uara_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rxd,
   input wire logic txd,
   input wire logic rxFullIrq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("no write answer");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("no read answer");
   chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
      s_axi_rdata == 32'h0) else $error("refused read data");
   chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("upper read bits set");
   chk_start_low: assert property ($fell(txd) |=> !txd [*7])
      else $error("start bit short");
   chk_rx_stop: assert property ($rose(rxFullIrq) |-> rxd && $past(rxd))
      else $error("reception ended off stop bit");
   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   cover property ($rose(rxFullIrq));
   cover property ($fell(txd));
endmodule : uara_uart_monitor

// ===== verif/uara_remote_port.sv
// Remote serial port model: echoes each received byte.
// Assumes 8N1 frames at BIT clocks per bit.
`timescale 1ns/100ps
module uara_remote_port #(
   parameter int BIT = 16
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic txd,
   output logic rxd,
   output int frames
);
   logic [7:0] b;
   initial begin
      rxd = 1'b1;
      frames = 0;
      wait (rst_b === 1'b1);
      forever begin
         @(negedge txd);
         repeat (BIT / 2) @(posedge clock);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clock);
            b[i] = txd;
         end
         repeat (BIT) @(posedge clock);
         rxd <= 1'b0;
         for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clock);
            rxd <= (i < 8) ? b[i] : 1'b1;
         end
         repeat (BIT) @(posedge clock);
         frames++;
      end
   end
endmodule : uara_remote_port

// ===== verif/test_uart_avg_rate_async.sv
// Self-checking bench: AXI4-Lite register access and echoed traffic.
// Assumes the remote port echoes each byte at 16 clocks per bit.
`timescale 1ns/100ps
module test_uart_avg_rate_async;
   import uara_pkg::*;
   logic clock = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, rxd, txd, txEmptyIrq, rxFullIrq;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
   logic [31:0] seed = 71645;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic clkEn = 1'b1;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] dmaTxData = 0, rxData, d[2];
   logic [33:0] expQ[$], e;
   int error_cnt = 0, num_checks = 0, cyc = 0, frames;
   uara_uart_avg_rate_async i_dut(.clock, .rst_b, .clkEn, .s_axi_awaddr,
      .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .tmrBaseTick(1'b0),
      .txEmptyIrq, .rxFullIrq, .dmaTxWrite(1'b0), .dmaTxData, .dmaRxRead(1'b0), .rxData);
   uara_remote_port #(.BIT(16)) i_far(.clock, .rst_b, .txd, .rxd, .frames);
   always #25 clock = ~clock;
   ////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   task automatic results;
      if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   task automatic wr(input logic [23:0] i, input logic [15:0] v);
      @(posedge clock);
      seed = xs(seed);
      s_axi_awaddr <= {6'h00, i, 2'h0};
      s_axi_wdata <= {16'h0, v};
      s_axi_awprot <= seed[2:0];
      dmaTxData <= seed[15:8];
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
         begin do @(posedge clock); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
         begin do @(posedge clock); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
      join
      while (s_axi_bvalid !== 1'b1) @(posedge clock);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [23:0] i, input logic [33:0] x);
      expQ.push_back(x);
      @(posedge clock);
      s_axi_araddr <= {6'h00, i, 2'h0};
      s_axi_arprot <= seed[5:3];
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : rd
   ////////////////////////////////
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         results();
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
         e = expQ.pop_front();
         num_checks++;
         if ({s_axi_rresp, s_axi_rdata} !== e) begin
            error_cnt++;
            $display("[FAIL] %0t read %h exp %h", $time, {s_axi_rresp, s_axi_rdata}, e);
         end
      end
   end
   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      rd(IDX_HALT, {RESP_OKAY, 16'h0, HALT_RST});
      rd(IDX_FLAG, 34'h84);
      rd(24'h000000, {RESP_SLVERR, 32'h0});
      wr(IDX_HALT, 16'h0000);
      wr(IDX_CTRL, 16'h0030);
      for (int n = 0; n < 2; n++) begin
         seed = xs(seed);
         d[n] = seed[7:0];
         wr(IDX_TXHOLD, {8'h00, d[n]});
         rd(IDX_FLAG, n ? 34'hC4 : 34'h84);
         wr(IDX_FLAG, 16'h007F);
         while (frames != n + 1) @(posedge clock);
         repeat (2) @(posedge clock);
         rd(IDX_FLAG, n ? 34'hE4 : 34'hC4);
         rd(IDX_RXHOLD, {26'h0, d[0]});
      end
      wr(IDX_RXHOLD, 16'h00FF);
      rd(IDX_RXHOLD, {26'h0, d[0]});
      wr(IDX_CTRL, 16'h0020);
      rd(IDX_FLAG, 34'hE4);
      wr(IDX_FLAG, 16'h009F);
      rd(IDX_FLAG, 34'h84);
      rd(IDX_TXHOLD, {26'h0, d[1]});
      wr(IDX_FRAME, 16'h0020);
      wr(IDX_CTRL, 16'h0030);
      wr(IDX_TXHOLD, 16'h0055);
      rd(IDX_FLAG, 34'h84);
      wr(IDX_FLAG, 16'h007F);
      while (frames != 3) @(posedge clock);
      repeat (40) @(posedge clock);
      rd(IDX_FLAG, 34'h8C);
      wr(IDX_FLAG, 16'h00F7);
      rd(IDX_FLAG, 34'h84);
      num_checks++;
      if (rxData !== d[0] || txEmptyIrq !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t pins", $time);
      end
      results();
   end
endmodule : test_uart_avg_rate_async
bind uara_uart_avg_rate_async uara_uart_monitor i_mon(.clock, .rst_b, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .rxFullIrq);
